// [src/slt_regs.svh]
/*
 * Register offsets, field positions, reset values and timing counts for
 * the transmit user port of the streaming link.
 * Assumes a 200 MHz core clock and a word-addressed Avalon-MM slave.
 */
`ifndef SLT_REGS_SVH
`define SLT_REGS_SVH

`define SLT_ADDR_W 4
`define SLT_REG_CTRL 4'h0
`define SLT_REG_GAP 4'h1
`define SLT_REG_STATUS 4'h2
`define SLT_REG_ERR 4'h3
`define SLT_REG_SYNC 4'h4
`define SLT_REG_BURSTS 4'h5

`define SLT_CTRL_ADV 0
`define SLT_CTRL_BURST 1
`define SLT_CTRL_ECC 2
`define SLT_CTRL_SOFT_RST 3
`define SLT_CTRL_RESET 4'h2
`define SLT_GAP_RESET 8'h00

`define SLT_ST_LINK_UP 0
`define SLT_ST_USER_RST 1
`define SLT_ST_IFC_RST 2
`define SLT_ST_STAGE_FULL 3
`define SLT_ST_CLK_SEEN 4

`define SLT_ERR_OVF 0
`define SLT_ERR_CORR 1
`define SLT_ERR_UNCORR 2
`define SLT_ERR_GAP 3

`define SLT_SYNC_LAST_POS 8

`define SLT_CLK_PERIOD_PS 5000
`define SLT_RST_SEQ_NS 100
`define SLT_RST_SEQ_CYC ((`SLT_RST_SEQ_NS * 1000 + `SLT_CLK_PERIOD_PS - 1) / `SLT_CLK_PERIOD_PS)
`define SLT_INIT_NS 250
`define SLT_INIT_CYC ((`SLT_INIT_NS * 1000 + `SLT_CLK_PERIOD_PS - 1) / `SLT_CLK_PERIOD_PS)

`endif

// [src/slt_pkg.sv]
/*
 * Types shared by the transmit user port: bus request carrier, lane
 * control word and reset sequencer states.
 * Assumes slt_regs.svh is on the include path.
 */
`include "slt_regs.svh"

package slt_pkg;

    typedef struct packed {
        logic read;
        logic write;
        logic [`SLT_ADDR_W-1:0] address;
        logic [31:0] writedata;
    } slt_avm_req_t;

    typedef struct packed {
        logic first;
        logic last;
        logic [7:0] sync;
    } slt_lane_ctl_t;

    typedef enum logic [1:0] {
        SLT_ST_HOLD,
        SLT_ST_SEQ,
        SLT_ST_INIT,
        SLT_ST_UP
    } slt_state_t;

endpackage

// [src/slt_sync2.sv]
/*
 * Two-flop synchroniser for pins that arrive from outside the clock.
 * Assumes each bit is an independent level; no bus coherence.
 */
`timescale 1ns/1ps

module slt_sync2 #(
    parameter int W = 1
) (
    input logic clock_in,
    input logic rst_in,
    input logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] stab_q;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            meta_q <= '0;
            stab_q <= '0;
        end
        else
        begin
            meta_q <= d_in;
            stab_q <= meta_q;
        end
    end

    assign q_out = stab_q;

endmodule // slt_sync2

// [src/slt_gap_chk.sv]
/*
 * Burst gap checker: counts idle cycles between a burst end and the
 * next burst start and flags a mismatch with the configured gap.
 * Assumes first/last strobes are already qualified by an accepted word.
 */
`timescale 1ns/1ps

module slt_gap_chk #(
    parameter int GAP_W = 8
) (
    input logic clock_in,
    input logic rst_in,
    input logic enable_in,
    input logic first_in,
    input logic last_in,
    input logic [GAP_W-1:0] gap_cfg_in,
    output logic gap_err_out
);

    logic in_gap_q;
    logic [GAP_W:0] cnt_q;
    logic err_q;
    wire cnt_max = &cnt_q;
    // one spare bit so a saturated count can never match the setting
    wire mismatch = cnt_q != {1'b0, gap_cfg_in};

    always_ff @(posedge clock_in)
    begin
        if (rst_in || !enable_in)
        begin
            in_gap_q <= 1'b0;
            cnt_q <= '0;
            err_q <= 1'b0;
        end
        else
        begin
            err_q <= first_in && in_gap_q && mismatch;
            if (last_in)
                cnt_q <= '0;
            else if (in_gap_q && !cnt_max)
                cnt_q <= cnt_q + 1'b1;
            if (last_in)
                in_gap_q <= 1'b1;
            else if (first_in)
                in_gap_q <= 1'b0;
        end
    end

    assign gap_err_out = err_q;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in || !enable_in);

    gap_flag_a: assert property (
        (first_in && in_gap_q && mismatch) |=> gap_err_out)
        else $error("gap mismatch not flagged");

endmodule // slt_gap_chk

// [src/slt_tx_port.sv]
/*
 * Transmit user port of a multi-lane streaming link: reset sequencing,
 * exported clocks, one-word adaptation stage toward the lane framer,
 * sync tag capture, error flags and an Avalon-MM register slave.
 * Assumes user data is presented on clock_in and that the lane framer
 * drains the stage with lane_ready_in.
 */
`timescale 1ns/1ps
`include "slt_regs.svh"

module slt_tx_port #(
    parameter int LANES = 1,
    parameter int SEQ_CYC = `SLT_RST_SEQ_CYC,
    parameter int INIT_CYC = `SLT_INIT_CYC,
    parameter int GAP_W = 8
) (
    input logic clock_in,
    input logic rst_in,
    input logic core_rst_in,
    input slt_pkg::slt_avm_req_t avm_in,
    output logic [31:0] avm_readdata_out,
    output logic avm_waitrequest_out,
    input logic user_clk_tx_in,
    output logic user_clk_tx_out,
    output logic user_clk_tx_oe_n_out,
    input logic user_rst_tx_in,
    output logic user_rst_tx_out,
    output logic user_rst_tx_oe_n_out,
    output logic ifc_rst_tx_out,
    output logic link_up_tx_out,
    input logic [64*LANES-1:0] tx_data_in,
    input logic [7:0] tx_sync_in,
    input logic tx_valid_in,
    input logic tx_burst_first_in,
    input logic tx_burst_last_in,
    input logic seu_corr_in,
    input logic seu_uncorr_in,
    output logic [3:0] error_tx_out,
    input logic lane_ready_in,
    output logic lane_valid_out,
    output logic [64*LANES-1:0] lane_data_out,
    output slt_pkg::slt_lane_ctl_t lane_ctl_out,
    output logic user_clk_rx_out,
    output logic user_rst_rx_out,
    output logic ifc_clk_rx_out,
    output logic ifc_rst_rx_out
);
    import slt_pkg::*;

    localparam logic [15:0] SEQ_LAST = 16'(SEQ_CYC - 1);
    localparam logic [15:0] INIT_LAST = 16'(INIT_CYC - 1);
    localparam int SEQ_LO = SEQ_CYC + 1;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] pin_s;
    logic usr_clk_s_q;
    logic [3:0] ctrl_q;

    slt_sync2 #(.W(3)) u_pin_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .d_in({core_rst_in, user_clk_tx_in, user_rst_tx_in}),
        .q_out(pin_s)
    );

    wire ctrl_adv = ctrl_q[`SLT_CTRL_ADV];
    wire ctrl_burst = ctrl_q[`SLT_CTRL_BURST];
    wire ctrl_ecc = ctrl_q[`SLT_CTRL_ECC];
    wire master_rst = pin_s[2] | ctrl_q[`SLT_CTRL_SOFT_RST];
    wire usr_rst_adv = ctrl_adv & pin_s[0];
    wire usr_clk_edge = ctrl_adv & (pin_s[1] ^ usr_clk_s_q);
    // CTRL, GAP and ERR registers survive a master reset so software can still see state
    wire mac_rst = rst_in | master_rst;
    wire stage_rst = mac_rst | usr_rst_adv;

    // ************************************************************
    // reset sequencer
    // ************************************************************
    slt_state_t state_q;
    slt_state_t state_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic busy_q;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            SLT_ST_HOLD:
            begin
                cnt_d = '0;
                state_d = SLT_ST_SEQ;
            end
            SLT_ST_SEQ:
            begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == SEQ_LAST)
                begin
                    cnt_d = '0;
                    state_d = SLT_ST_INIT;
                end
            end
            SLT_ST_INIT:
            begin
                cnt_d = cnt_q + 16'h0001;
                if (usr_rst_adv)
                    cnt_d = '0;
                else if (cnt_q == INIT_LAST)
                begin
                    cnt_d = '0;
                    state_d = SLT_ST_UP;
                end
            end
            SLT_ST_UP:
            begin
                if (usr_rst_adv)
                    state_d = SLT_ST_INIT;
            end
            default:
            begin
                state_d = SLT_ST_HOLD;
                cnt_d = '0;
            end
        endcase
        if (master_rst)
        begin
            state_d = SLT_ST_HOLD;
            cnt_d = '0;
        end
    end

    wire busy_d = (state_d == SLT_ST_HOLD) || (state_d == SLT_ST_SEQ);
    wire up_d = state_d == SLT_ST_UP;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_q <= SLT_ST_HOLD;
            cnt_q <= '0;
            busy_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end

    // ************************************************************
    // exported resets and link ready
    // ************************************************************
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            user_rst_tx_out <= 1'b1;
            user_rst_tx_oe_n_out <= 1'b0;
            ifc_rst_tx_out <= 1'b1;
            user_rst_rx_out <= 1'b1;
            ifc_rst_rx_out <= 1'b1;
            link_up_tx_out <= 1'b0;
        end
        else
        begin
            user_rst_tx_out <= busy_d & ~ctrl_adv;
            user_rst_tx_oe_n_out <= ctrl_adv;
            ifc_rst_tx_out <= busy_d | ~ctrl_adv;
            user_rst_rx_out <= busy_d | ctrl_adv;
            ifc_rst_rx_out <= busy_d | ~ctrl_adv;
            link_up_tx_out <= up_d;
        end
    end

    // ************************************************************
    // clock unit: only rst_in touches it, a master reset does not
    // ************************************************************
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            user_clk_tx_out <= 1'b0;
            user_clk_tx_oe_n_out <= 1'b0;
            user_clk_rx_out <= 1'b0;
            ifc_clk_rx_out <= 1'b0;
        end
        else
        begin
            user_clk_tx_out <= ~ctrl_adv & ~user_clk_tx_out;
            user_clk_tx_oe_n_out <= ctrl_adv;
            user_clk_rx_out <= ~ctrl_adv & ~user_clk_rx_out;
            ifc_clk_rx_out <= ctrl_adv & ~ifc_clk_rx_out;
        end
    end

    // ************************************************************
    // adaptation stage
    // ************************************************************
    // a single word of slack: the framer must drain it every cycle
    // in which new data arrives, otherwise the new word is lost
    logic stage_full_q;
    logic [7:0] sync_first_q;
    logic [7:0] sync_last_q;
    logic [15:0] burst_cnt_q;
    logic clk_seen_q;

    wire offered = tx_valid_in & link_up_tx_out;
    wire accept = offered & (~stage_full_q | lane_ready_in);
    wire overflow = offered & stage_full_q & ~lane_ready_in;
    wire acc_first = accept & tx_burst_first_in;
    wire acc_last = accept & tx_burst_last_in;
    wire tag_cycle = acc_first | acc_last;
    wire stage_full_d = accept | (stage_full_q & ~lane_ready_in);

    always_ff @(posedge clock_in)
    begin
        if (stage_rst)
            stage_full_q <= 1'b0;
        else
            stage_full_q <= stage_full_d;
    end

    always_ff @(posedge clock_in)
    begin
        if (accept)
        begin
            lane_data_out <= tx_data_in;
            lane_ctl_out.first <= tx_burst_first_in;
            lane_ctl_out.last <= tx_burst_last_in;
            lane_ctl_out.sync <= tag_cycle ? tx_sync_in : 8'h00;
        end
        else if (rst_in)
        begin
            lane_data_out <= '0;
            lane_ctl_out <= '0;
        end
    end

    assign lane_valid_out = stage_full_q;

    always_ff @(posedge clock_in)
    begin
        if (mac_rst)
        begin
            sync_first_q <= 8'h00;
            sync_last_q <= 8'h00;
            burst_cnt_q <= 16'h0000;
            clk_seen_q <= 1'b0;
            usr_clk_s_q <= 1'b0;
        end
        else
        begin
            if (acc_first)
                sync_first_q <= tx_sync_in;
            if (acc_last)
                sync_last_q <= tx_sync_in;
            if (acc_first)
                burst_cnt_q <= burst_cnt_q + 16'h0001;
            clk_seen_q <= clk_seen_q | usr_clk_edge;
            usr_clk_s_q <= pin_s[1];
        end
    end

    // ************************************************************
    // error flags
    // ************************************************************
    logic [GAP_W-1:0] gap_q;
    logic gap_err;
    logic [3:0] err_now;
    logic [3:0] err_sticky_q;
    logic [3:0] err_clr;

    slt_gap_chk #(.GAP_W(GAP_W)) u_gap_chk (
        .clock_in(clock_in),
        .rst_in(mac_rst),
        .enable_in(ctrl_burst & link_up_tx_out),
        .first_in(acc_first),
        .last_in(acc_last),
        .gap_cfg_in(gap_q),
        .gap_err_out(gap_err)
    );

    assign err_now[`SLT_ERR_OVF] = overflow;
    assign err_now[`SLT_ERR_CORR] = ctrl_ecc & seu_corr_in;
    assign err_now[`SLT_ERR_UNCORR] = ctrl_ecc & seu_uncorr_in;
    assign err_now[`SLT_ERR_GAP] = gap_err;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            error_tx_out <= 4'h0;
            err_sticky_q <= 4'h0;
        end
        else
        begin
            error_tx_out <= err_now;
            // a new event in the clear cycle stays set
            err_sticky_q <= err_now | (err_sticky_q & ~err_clr);
        end
    end

    // ************************************************************
    // Avalon-MM slave: one wait state on every access
    // ************************************************************
    logic [31:0] rd_mux;

    wire req = avm_in.read | avm_in.write;
    wire take = req & avm_waitrequest_out;
    wire wr_done = avm_in.write & ~avm_waitrequest_out;
    wire sel_ctrl = avm_in.address == `SLT_REG_CTRL;
    wire sel_gap = avm_in.address == `SLT_REG_GAP;
    wire sel_status = avm_in.address == `SLT_REG_STATUS;
    wire sel_err = avm_in.address == `SLT_REG_ERR;
    wire sel_sync = avm_in.address == `SLT_REG_SYNC;
    wire sel_bursts = avm_in.address == `SLT_REG_BURSTS;
    wire [31:0] status_w = (32'(link_up_tx_out) << `SLT_ST_LINK_UP)
        | (32'(user_rst_tx_out) << `SLT_ST_USER_RST)
        | (32'(ifc_rst_tx_out) << `SLT_ST_IFC_RST)
        | (32'(stage_full_q) << `SLT_ST_STAGE_FULL)
        | (32'(clk_seen_q) << `SLT_ST_CLK_SEEN);
    wire [31:0] sync_w = (32'(sync_last_q) << `SLT_SYNC_LAST_POS)
        | 32'(sync_first_q);

    assign err_clr = (wr_done && sel_err) ? avm_in.writedata[3:0] : 4'h0;
    assign rd_mux = sel_ctrl ? 32'(ctrl_q)
        : sel_gap ? 32'(gap_q)
        : sel_status ? status_w
        : sel_err ? 32'(err_sticky_q)
        : sel_sync ? sync_w
        : sel_bursts ? 32'(burst_cnt_q)
        : 32'h0000_0000;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            avm_waitrequest_out <= 1'b1;
            avm_readdata_out <= 32'h0000_0000;
        end
        else
        begin
            avm_waitrequest_out <= ~take;
            if (take && avm_in.read)
                avm_readdata_out <= rd_mux;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ctrl_q <= `SLT_CTRL_RESET;
            gap_q <= GAP_W'(`SLT_GAP_RESET);
        end
        else if (wr_done)
        begin
            if (sel_ctrl)
                ctrl_q <= avm_in.writedata[3:0];
            if (sel_gap)
                gap_q <= avm_in.writedata[GAP_W-1:0];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence ovf_s;
        tx_valid_in && link_up_tx_out && stage_full_q && !lane_ready_in;
    endsequence

    sequence fell_master_s;
        $fell(master_rst);
    endsequence

    property seq_len_p;
        disable iff (rst_in || master_rst)
        fell_master_s |-> busy_q ##[SEQ_LO:SEQ_LO] !busy_q;
    endproperty

    seq_release_a: assert property (seq_len_p)
        else $error("reset sequence length wrong");
    ifc_reset_hold_a: assert property (master_rst |=> ifc_rst_tx_out)
        else $error("interface reset not held");
    link_ready_a: assert property (
        $rose(link_up_tx_out) |-> $past(state_q == SLT_ST_INIT)
        && !busy_q)
        else $error("link ready rose outside init end");
    master_drop_a: assert property (
        master_rst |=> !link_up_tx_out && state_q == SLT_ST_HOLD)
        else $error("master reset did not clear logic");
    clk_free_a: assert property (
        (!ctrl_adv && !master_rst)[*2] |=>
        user_clk_rx_out != $past(user_clk_rx_out))
        else $error("receive user clock stalled");
    ifc_clk_run_a: assert property (
        ctrl_adv[*2] |=> ifc_clk_rx_out != $past(ifc_clk_rx_out))
        else $error("sink interface clock stalled");
    clk_dir_a: assert property (
        ctrl_adv |=> user_clk_tx_oe_n_out && !user_clk_tx_out)
        else $error("tx clock driven in advanced mode");
    user_flush_a: assert property (usr_rst_adv |=> !lane_valid_out)
        else $error("stage not cleared by user reset");
    ovf_flag_a: assert property (
        ovf_s |=> error_tx_out[`SLT_ERR_OVF] && err_sticky_q[`SLT_ERR_OVF])
        else $error("overflow not flagged");
    seu_corr_a: assert property (
        error_tx_out[`SLT_ERR_CORR] == $past(ctrl_ecc && seu_corr_in))
        else $error("corrected upset flag wrong");
    seu_unc_a: assert property (
        error_tx_out[`SLT_ERR_UNCORR] == $past(ctrl_ecc && seu_uncorr_in))
        else $error("uncorrected upset flag wrong");
    tag_carry_a: assert property (
        (accept && tx_burst_first_in) |=> lane_valid_out
        && lane_ctl_out.first && lane_ctl_out.sync == $past(tx_sync_in))
        else $error("start tag not carried");
    bus_wait_a: assert property (
        take |=> !avm_waitrequest_out ##1 avm_waitrequest_out)
        else $error("wait state length wrong");

endmodule // slt_tx_port

// [testbench/slt_user_model.sv]
/* user-side stream source for the tx port bench.
   assumes the port samples its stream inputs on rising clock_in. */
`timescale 1ns/1ps

module slt_user_model #(
    parameter int LANES = 1
) (
    input wire logic clock_in,
    input wire logic link_up_in,
    output logic [64*LANES-1:0] tx_data_out,
    output logic [7:0] tx_sync_out,
    output logic tx_valid_out,
    output logic tx_burst_first_out,
    output logic tx_burst_last_out
);
    // words that waited in vain for link ready, read out by the bench
    int n_late = 0;

    initial
    begin
        tx_data_out = '0;
        tx_sync_out = 8'h00;
        tx_valid_out = 1'b0;
        tx_burst_first_out = 1'b0;
        tx_burst_last_out = 1'b0;
    end

    // no word before the link is up, unless 500 cycles pass first
    task automatic word(input logic f, input logic l, input logic [7:0] s,
        input logic [64*LANES-1:0] d);
        int n;
        n = 0;
        while (link_up_in !== 1'b1 && n < 500)
        begin
            @(posedge clock_in);
            n++;
        end
        if (link_up_in !== 1'b1)
            n_late++;
        @(posedge clock_in);
        tx_valid_out <= 1'b1;
        tx_burst_first_out <= f;
        tx_burst_last_out <= l;
        tx_sync_out <= s;
        tx_data_out <= d;
    endtask

    // idle lines flip so stale data never looks held
    task automatic idle(input int n);
        @(posedge clock_in);
        tx_valid_out <= 1'b0;
        tx_burst_first_out <= 1'b0;
        tx_burst_last_out <= 1'b0;
        tx_data_out <= ~tx_data_out;
        tx_sync_out <= ~tx_sync_out;
        repeat (n - 1) @(posedge clock_in);
    endtask
endmodule // slt_user_model

// [testbench/streaming_link_tx_user_port_test.sv]
/* self-checking bench for the tx user port: resets, clocks, stream,
   errors and registers. assumes short sequencer counts of 2 and 2. */
`timescale 1ns/1ps

module streaming_link_tx_user_port_test;
    import slt_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in, core_rst, usr_rst, seu_c, seu_u, lane_rdy, utx_clk;
    slt_avm_req_t avm;
    logic b, uclk_tx, rst_oe_n, irst_rx;
    logic [31:0] rdata, q;
    logic wreq, clk_oe_n, ursr_tx, ifc_tx, up, lvalid, a;
    logic uclk_rx, ursr_rx, iclk_rx, tval, tfirst, tlast;
    logic [3:0] err;
    logic [63:0] tdata, ldata;
    logic [7:0] tsync;
    slt_lane_ctl_t lctl;
    int n_errors = 0;
    int cmp_count = 0;
    int gap_pulses = 0;

    always #2.5 clock_in = ~clock_in;
    always @(posedge clock_in) if (err[3] === 1'b1) gap_pulses++;

    slt_tx_port #(.LANES(1), .SEQ_CYC(2), .INIT_CYC(2)) i_dut (
        .clock_in(clock_in), .rst_in(rst_in), .core_rst_in(core_rst),
        .avm_in(avm), .avm_readdata_out(rdata), .avm_waitrequest_out(wreq),
        .user_clk_tx_in(utx_clk), .user_clk_tx_out(uclk_tx),
        .user_clk_tx_oe_n_out(clk_oe_n), .user_rst_tx_in(usr_rst),
        .user_rst_tx_out(ursr_tx), .user_rst_tx_oe_n_out(rst_oe_n),
        .ifc_rst_tx_out(ifc_tx), .link_up_tx_out(up), .tx_data_in(tdata),
        .tx_sync_in(tsync), .tx_valid_in(tval), .tx_burst_first_in(tfirst),
        .tx_burst_last_in(tlast), .seu_corr_in(seu_c), .seu_uncorr_in(seu_u),
        .error_tx_out(err), .lane_ready_in(lane_rdy), .lane_valid_out(lvalid),
        .lane_data_out(ldata), .lane_ctl_out(lctl),
        .user_clk_rx_out(uclk_rx), .user_rst_rx_out(ursr_rx),
        .ifc_clk_rx_out(iclk_rx), .ifc_rst_rx_out(irst_rx));

    slt_user_model #(.LANES(1)) i_user (
        .clock_in(clock_in), .link_up_in(up), .tx_data_out(tdata),
        .tx_sync_out(tsync), .tx_valid_out(tval),
        .tx_burst_first_out(tfirst), .tx_burst_last_out(tlast));

    // ********************
    // shared tasks
    // ********************
    task automatic finish_test();
        n_errors += i_user.n_late;
        $display("Checks %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        avm <= '{read: !w, write: w, address: ad, writedata: d};
        do
        begin
            @(posedge clock_in);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        q = rdata;
        avm <= '0;
        if (n >= 50)
        begin
            n_errors++;
            finish_test();
        end
    endtask

    task automatic errchk(input logic [31:0] e);
        bus(1'b0, 4'h3, 32'h0);
        chk(q, e);
        bus(1'b1, 4'h3, 32'hF);
    endtask

    task automatic wait_up();
        int n;
        for (n = 0; n < 200 && up !== 1'b1; n++) @(posedge clock_in);
        if (n >= 200)
        begin
            n_errors++;
            finish_test();
        end
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic t_bring_up();
        chk(up, 1'b0);
        chk(ursr_tx, 1'b1);
        wait_up();
        chk(ursr_tx, 1'b0);
        chk(ursr_rx, 1'b0);
        chk(clk_oe_n, 1'b0);
        chk(rst_oe_n, 1'b0);
        chk(irst_rx, 1'b1);
        a = uclk_rx;
        b = uclk_tx;
        @(posedge clock_in);
        chk(uclk_rx, !a);
        chk(uclk_tx, !b);
        bus(1'b0, 4'h0, 32'h0);
        chk(q, 32'h2);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h5);
        bus(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
    endtask

    task automatic t_stream_ovf();
        i_user.word(1'b1, 1'b0, 8'h5A, 64'h0123456789ABCDEF);
        i_user.word(1'b0, 1'b1, 8'h00, 64'hFEDCBA9876543210);
        i_user.idle(4);
        bus(1'b0, 4'h4, 32'h0);
        chk(q, 32'h005A);
        lane_rdy <= 1'b0;
        i_user.word(1'b0, 1'b0, 8'h00, 64'hA);
        i_user.word(1'b0, 1'b0, 8'h00, 64'hB);
        i_user.idle(3);
        chk(lvalid, 1'b1);
        chk(ldata, 64'hA);
        chk(lctl, '0);
        errchk(32'h1);
        lane_rdy <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk(lvalid, 1'b0);
    endtask

    // ecc on then off, corrected and uncorrected reports
    task automatic t_ecc();
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, 4'h0, i[1] ? 32'h2 : 32'h6);
            @(posedge clock_in);
            seu_c <= !i[0];
            seu_u <= i[0];
            @(posedge clock_in);
            seu_c <= 1'b0;
            seu_u <= 1'b0;
            repeat (2) @(posedge clock_in);
            errchk(i[1] ? 32'h0 : (i[0] ? 32'h4 : 32'h2));
        end
    endtask

    // long gap and gap of one mismatch, gap of two matches
    task automatic t_gap();
        bus(1'b1, 4'h1, 32'h2);
        gap_pulses = 0;
        i_user.word(1'b1, 1'b1, 8'h00, 64'h1);
        i_user.idle(2);
        i_user.word(1'b1, 1'b1, 8'h00, 64'h2);
        i_user.idle(1);
        i_user.word(1'b1, 1'b1, 8'h00, 64'h3);
        i_user.idle(5);
        chk(gap_pulses, 2);
        errchk(32'h8);
        bus(1'b0, 4'h5, 32'h0);
        chk(q, 32'h4);
    endtask

    task automatic t_master_reset();
        @(posedge clock_in);
        core_rst <= 1'b1;
        repeat (5) @(posedge clock_in);
        chk(up, 1'b0);
        chk(ursr_tx, 1'b1);
        chk(ursr_rx, 1'b1);
        core_rst <= 1'b0;
        wait_up();
        bus(1'b0, 4'h1, 32'h0);
        chk(q, 32'h2);
    endtask

    // advanced clocking: pin enables, interface reset, stage flush
    task automatic t_advanced();
        bus(1'b1, 4'h0, 32'h3);
        utx_clk <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk(clk_oe_n, 1'b1);
        chk(rst_oe_n, 1'b1);
        chk(uclk_tx, 1'b0);
        a = iclk_rx;
        @(posedge clock_in);
        chk(iclk_rx, !a);
        wait_up();
        chk(ifc_tx, 1'b0);
        lane_rdy <= 1'b0;
        i_user.word(1'b0, 1'b0, 8'h00, 64'h7);
        i_user.idle(2);
        chk(lvalid, 1'b1);
        usr_rst <= 1'b1;
        repeat (5) @(posedge clock_in);
        chk(lvalid, 1'b0);
        chk(up, 1'b0);
        usr_rst <= 1'b0;
        lane_rdy <= 1'b1;
        wait_up();
        chk(irst_rx, 1'b0);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h11);
    endtask

    initial
    begin
        rst_in <= 1'b1;
        {core_rst, usr_rst, seu_c, seu_u, utx_clk} <= 5'h00;
        lane_rdy <= 1'b1;
        avm <= '0;
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        t_bring_up();
        t_stream_ovf();
        t_ecc();
        t_gap();
        t_master_reset();
        t_advanced();
        finish_test();
    end
endmodule // streaming_link_tx_user_port_test
